// [rtl/uart9_pkg.sv]
// Shared constants and types for the nine-bit multidrop serial port.
// How it works
// - Frame: start, 8 data LSB first, ninth, stop
// - Ninth transmitted bit comes from control bit
// - Received ninth bit stored; stop bit unchecked
// - Writing data register while idle launches a frame
// - Transmit flag sets as stop bit begins
// - Receive only while receive enable set
// - Accepted frame loads buffer, ninth, flag
// - Rejected frame changes nothing
// - Either flag setting raises enabled interrupt
`default_nettype none
package uart9_pkg;

    // Register byte offsets.
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] DATA_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [3:0] MASK_OFS = 4'hc;

    // Control register fields.
    localparam int CTRL_RXEN_BIT = 0;
    localparam int CTRL_MCE_BIT = 1;
    localparam int CTRL_TB8_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Status and mask register fields.
    localparam int STAT_TXDONE_BIT = 0;
    localparam int STAT_RXDONE_BIT = 1;
    localparam int STAT_RB8_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam logic [7:0] BUF_RESET = 8'h00;

    // Frame geometry.
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = 11;
    localparam logic [3:0] STOP_IDX = 4'ha;
    localparam logic [3:0] NINTH_IDX = 4'h9;
    localparam logic [3:0] LAST_RX_IDX = 4'h8;

    // Default bit time in clock cycles.
    localparam int BIT_CYCLES_DEFAULT = 434;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One character: eight data bits and the ninth bit.
    typedef struct packed {
        logic ninth;
        logic [DATA_BITS-1:0] data;
    } char_s;

    // Receiver states, Gray coded along the frame.
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_e;

endpackage
`default_nettype wire

// [rtl/uart9_tx.sv]
// Transmit shifter that serialises one eleven-bit frame.
`timescale 1ns/1ps
`default_nettype none
module uart9_tx
    import uart9_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic start,
    input wire char_s frame,
    output logic txd,
    output logic busy,
    output logic stop_begin
);

    logic [15:0] cnt_q;
    logic [3:0] idx_q;
    logic [FRAME_BITS-1:0] sh_q;
    logic busy_q;
    logic txd_q;
    logic stop_q;
    logic ninth_q;
    logic bit_end;

    assign bit_end = (cnt_q == 16'(BIT_CYCLES - 1));
    assign txd = txd_q;
    assign busy = busy_q;
    assign stop_begin = stop_q;

    // Bit timing and frame shifting; a start while busy is ignored.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            cnt_q <= 16'h0000;
            idx_q <= 4'h0;
            sh_q <= '1;
            txd_q <= 1'b1;
            ninth_q <= 1'b0;
        end else if (ce) begin
            if (!busy_q && start) begin
                sh_q <= {1'b1, frame.ninth, frame.data, 1'b0};
                ninth_q <= frame.ninth;
                txd_q <= 1'b0;
                busy_q <= 1'b1;
                cnt_q <= 16'h0000;
                idx_q <= 4'h0;
            end else if (busy_q) begin
                if (bit_end) begin
                    cnt_q <= 16'h0000;
                    if (idx_q == STOP_IDX) begin
                        busy_q <= 1'b0;
                    end else begin
                        sh_q <= {1'b1, sh_q[FRAME_BITS-1:1]};
                        txd_q <= sh_q[1];
                        idx_q <= idx_q + 4'h1;
                    end
                end else begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
        end
    end

    // One-cycle pulse as the stop bit starts on the line.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stop_q <= 1'b0;
        end else if (ce) begin
            stop_q <= busy_q && bit_end && (idx_q == NINTH_IDX);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_launch;
        ce && start && !busy_q;
    endsequence

    a_tx_start_bit: assert property (s_launch |=> !txd_q && busy_q)
        else $error("start bit not driven low after launch");
    a_tx_stop_high: assert property (
        stop_q |-> txd_q && busy_q && idx_q == STOP_IDX)
        else $error("stop pulse outside the stop bit");
    a_tx_ninth_bit: assert property (
        busy_q && idx_q == NINTH_IDX |-> txd_q == ninth_q)
        else $error("ninth bit on line differs from latched value");

endmodule
`default_nettype wire

// [rtl/uart9_top.sv]
// Nine-bit multidrop serial port with its register slave.
`timescale 1ns/1ps
`default_nettype none
module uart9_top
    import uart9_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT,
    parameter int ADDR_W = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic rxd,
    output logic txd,
    output logic irq
);

    localparam int HALF_CYCLES = BIT_CYCLES / 2;

    ////////////////////////////////////////////////////////////////////////
    // Register bus slave.

    logic aw_have_q;
    logic w_have_q;
    logic [3:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_write;
    logic wr_ok;

    // Ready drops with the clock enable so no beat is taken while frozen.
    assign awready = ce && !aw_have_q;
    assign wready = ce && !w_have_q;
    assign arready = ce && !rvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // Only aligned words inside the four-register window are mapped.
    assign wr_ok = (aw_addr_q[1:0] == 2'h0);
    assign do_write = ce && aw_have_q && w_have_q && !bvalid_q;

    // Address and data are held separately so either may come first.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_have_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr[3:0];
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_data_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Write response, one cycle after both halves are held.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-visible state.

    logic [2:0] ctrl_q;
    logic [1:0] mask_q;
    logic tx_done_q;
    logic rx_done_q;
    logic rx_ninth_q;
    logic [7:0] rx_buf_q;
    logic tx_busy;
    logic tx_stop;
    logic tx_start;
    logic wr_data;
    logic wr_stat;
    logic accept;
    logic frame_end;
    char_s tx_char;
    logic [8:0] rx_sh_q;

    assign wr_data = do_write && wr_ok && w_lane_q && (aw_addr_q == DATA_OFS);
    assign wr_stat = do_write && wr_ok && w_lane_q && (aw_addr_q == STAT_OFS);
    // A data write while a frame is going out is dropped, not queued.
    assign tx_start = wr_data && !tx_busy;
    assign tx_char.data = w_data_q;
    assign tx_char.ninth = ctrl_q[CTRL_TB8_BIT];

    // Control and mask registers.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
            mask_q <= MASK_RESET;
        end else if (ce && do_write && wr_ok && w_lane_q) begin
            if (aw_addr_q == CTRL_OFS) begin
                ctrl_q <= w_data_q[2:0];
            end
            if (aw_addr_q == MASK_OFS) begin
                mask_q <= w_data_q[1:0];
            end
        end
    end

    // Sticky flags: a hardware set beats a write-one clear in one cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_done_q <= 1'b0;
            rx_done_q <= 1'b0;
        end else if (ce) begin
            if (tx_stop) begin
                tx_done_q <= 1'b1;
            end else if (wr_stat && w_data_q[STAT_TXDONE_BIT]) begin
                tx_done_q <= 1'b0;
            end
            if (accept) begin
                rx_done_q <= 1'b1;
            end else if (wr_stat && w_data_q[STAT_RXDONE_BIT]) begin
                rx_done_q <= 1'b0;
            end
        end
    end

    // Receive buffer and ninth bit load only on an accepted frame.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_buf_q <= BUF_RESET;
            rx_ninth_q <= 1'b0;
        end else if (ce && accept) begin
            rx_buf_q <= rx_sh_q[7:0];
            rx_ninth_q <= rx_sh_q[8];
        end
    end

    // Interrupt is a level while any unmasked flag is set.
    assign irq = |({rx_done_q, tx_done_q} & mask_q);

    // Read path; reads have no side effects.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid_q <= 1'b1;
                rresp_q <= (araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
                unique case (araddr[3:0])
                    CTRL_OFS: rdata_q <= {29'h0, ctrl_q};
                    DATA_OFS: rdata_q <= {24'h0, rx_buf_q};
                    STAT_OFS: rdata_q <= {28'h0, tx_busy, rx_ninth_q,
                                          rx_done_q, tx_done_q};
                    MASK_OFS: rdata_q <= {30'h0, mask_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter.

    uart9_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .start(tx_start),
        .frame(tx_char),
        .txd(txd),
        .busy(tx_busy),
        .stop_begin(tx_stop)
    );

    ////////////////////////////////////////////////////////////////////////
    // Receiver.

    rx_state_e rx_state_q;
    logic rxd_prev_q;
    logic [15:0] rx_cnt_q;
    logic [3:0] rx_idx_q;
    logic rx_bit_end;
    logic rx_half;

    assign rx_bit_end = (rx_cnt_q == 16'(BIT_CYCLES - 1));
    assign rx_half = (rx_cnt_q == 16'(HALF_CYCLES - 1));
    // The frame ends at mid stop bit, but the stop bit level is never sampled.
    assign frame_end = ce && (rx_state_q == RX_STOP) && rx_bit_end;
    assign accept = frame_end && !rx_done_q &&
                    (!ctrl_q[CTRL_MCE_BIT] || rx_sh_q[8]);

    // Line history for the start edge.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxd_prev_q <= 1'b1;
        end else if (ce) begin
            rxd_prev_q <= rxd;
        end
    end

    // Frame walker; clearing receive enable aborts a frame in flight.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_q <= RX_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 9'h000;
        end else if (ce) begin
            if (!ctrl_q[CTRL_RXEN_BIT]) begin
                rx_state_q <= RX_IDLE;
            end else begin
                unique case (rx_state_q)
                    RX_IDLE: begin
                        rx_cnt_q <= 16'h0000;
                        if (rxd_prev_q && !rxd) begin
                            rx_state_q <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (rx_half) begin
                            rx_cnt_q <= 16'h0000;
                            rx_idx_q <= 4'h0;
                            // A glitch shorter than half a bit is dropped.
                            rx_state_q <= rxd ? RX_IDLE : RX_DATA;
                        end else begin
                            rx_cnt_q <= rx_cnt_q + 16'h0001;
                        end
                    end
                    RX_DATA: begin
                        if (rx_bit_end) begin
                            rx_cnt_q <= 16'h0000;
                            rx_sh_q <= {rxd, rx_sh_q[8:1]};
                            rx_idx_q <= rx_idx_q + 4'h1;
                            if (rx_idx_q == LAST_RX_IDX) begin
                                rx_state_q <= RX_STOP;
                            end
                        end else begin
                            rx_cnt_q <= rx_cnt_q + 16'h0001;
                        end
                    end
                    RX_STOP: begin
                        if (rx_bit_end) begin
                            rx_cnt_q <= 16'h0000;
                            rx_state_q <= RX_IDLE;
                        end else begin
                            rx_cnt_q <= rx_cnt_q + 16'h0001;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_good_frame;
        frame_end && !rx_done_q;
    endsequence

    a_tx_launch: assert property (tx_start |=> tx_busy)
        else $error("data write did not start a frame");
    a_rx_gate: assert property (
        ce && !ctrl_q[CTRL_RXEN_BIT] |=> rx_state_q == RX_IDLE)
        else $error("receiver active while disabled");
    a_rx_filter: assert property (
        accept && ctrl_q[CTRL_MCE_BIT] |-> rx_sh_q[8])
        else $error("data byte accepted while filtering");
    a_rx_store: assert property (
        s_good_frame ##0 (!ctrl_q[CTRL_MCE_BIT] || rx_sh_q[8]) |=>
        rx_done_q &&
        {rx_ninth_q, rx_buf_q} == $past(rx_sh_q))
        else $error("accepted frame not stored");
    a_rx_hold: assert property (
        frame_end && !accept |=> $stable(rx_buf_q) && $stable(rx_ninth_q))
        else $error("rejected frame changed the buffer");
    a_irq_raise: assert property (
        $rose(rx_done_q) && mask_q[STAT_RXDONE_BIT] |-> irq)
        else $error("receive flag did not raise interrupt");
    a_flag_sticky: assert property (
        tx_done_q && !wr_stat |=> tx_done_q)
        else $error("transmit flag cleared by hardware");
    a_start_detect: assert property (
        ce && ctrl_q[CTRL_RXEN_BIT] && rx_state_q == RX_IDLE &&
        rxd_prev_q && !rxd |=> rx_state_q == RX_START)
        else $error("falling edge missed by receiver");

endmodule
`default_nettype wire

// [testbench/serial_node.sv]
// Behavioural far-end node on the shared nine-bit serial line.
`timescale 1ns/1ps
`default_nettype none
module serial_node
    import uart9_pkg::*;
#(
    parameter int BIT_CYCLES = 8
) (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    char_s got_char;
    logic got_stop;
    int got_count;
    logic [9:0] frame_bits;

    // The line has a pull-up, so it idles high between frames.
    initial begin
        line_out = 1'b1;
        got_count = 0;
        got_char = '0;
        got_stop = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sends one frame; a low stop bit lets the bench test a bad stop.
    task automatic send(input char_s c, input logic stop);
        logic [10:0] bits;
        bits = {stop, c.ninth, c.data, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_out <= bits[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask

    // A low pulse shorter than half a bit, which the receiver must drop.
    task automatic glitch();
        line_out <= 1'b0;
        repeat (BIT_CYCLES / 4) @(posedge clk);
        line_out <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Samples each bit of a frame from the block at the middle of the bit.
    always begin
        @(negedge line_in);
        repeat (BIT_CYCLES / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            frame_bits[i] = line_in;
            repeat (BIT_CYCLES) @(posedge clk);
        end
        got_stop = line_in;
        got_char = {frame_bits[9], frame_bits[8:1]};
        got_count++;
    end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the nine-bit multidrop serial port.
`timescale 1ns/1ps
`default_nettype none
module tb
    import uart9_pkg::*;
;
    localparam int BIT = 8;
    localparam int LIMIT = 2000;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic awvalid = 1'b0;
    logic awready;
    logic [3:0] awaddr = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic bvalid;
    logic bready = 1'b0;
    logic [1:0] bresp;
    logic arvalid = 1'b0;
    logic arready;
    logic [3:0] araddr = 4'h0;
    logic rvalid;
    logic rready = 1'b0;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rxd;
    logic txd;
    logic irq;
    int cyc = 0;
    int mismatches = 0;
    int checks = 0;

    // Free-running clock and a cycle count for timing checks.
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    uart9_top #(.BIT_CYCLES(BIT), .ADDR_W(4)) dut_u (.clk(clk),
        .reset_n(reset_n), .ce(ce), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .rxd(rxd), .txd(txd), .irq(irq));

    serial_node #(.BIT_CYCLES(BIT)) node_u (.clk(clk), .line_in(txd),
        .line_out(rxd));

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Every polling wait counts edges; running out of the bound ends the run.
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > LIMIT) begin
            check(32'h0, 32'h1);
            test_done();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Address and data go out together and each drops once it is taken.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
            input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        int n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            tick(n);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        // Raised only now, so back-to-back calls never flip it in one step.
        bready <= 1'b1;
        do tick(n); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, r});
    endtask

    // Read data is only compared when OKAY is the expected response.
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] exp,
            input logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do tick(n); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check({30'h0, rresp}, {30'h0, r});
        if (r == RESP_OKAY) begin
            check(rdata, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One outgoing frame; a second write while busy must be dropped.
    task automatic tx_one(input logic [7:0] b, input logic nb);
        int base;
        int t0;
        int n;
        base = node_u.got_count;
        n = 0;
        axi_wr(CTRL_OFS, {29'h0, nb, 2'h0}, RESP_OKAY);
        axi_wr(DATA_OFS, {24'h0, b}, RESP_OKAY);
        t0 = cyc;
        axi_wr(DATA_OFS, 32'h11, RESP_OKAY);
        while (irq !== 1'b1) tick(n);
        check({31'h0, txd}, 32'h1);
        check({31'h0, (cyc - t0 >= 79 && cyc - t0 <= 84)}, 32'h1);
        while (node_u.got_count == base) tick(n);
        check({23'h0, node_u.got_char}, {23'h0, nb, b});
        check({31'h0, node_u.got_stop}, 32'h1);
        repeat (BIT * 3) @(posedge clk);
        check(32'(node_u.got_count), 32'(base + 1));
        axi_rd(STAT_OFS, 32'h1, RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        axi_wr(STAT_OFS, 32'h1, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h0, RESP_OKAY);
        check({31'h0, irq}, 32'h0);
    endtask

    // One incoming frame, then a few idle cycles for the load to land.
    task automatic rx_one(input char_s c, input logic stop);
        node_u.send(c, stop);
        repeat (6) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
        axi_rd(DATA_OFS, 32'h0, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h0, RESP_OKAY);
        axi_rd(MASK_OFS, 32'h0, RESP_OKAY);
        // With the clock enable low no bus beat may be taken.
        ce <= 1'b0;
        @(posedge clk);
        check({29'h0, awready, wready, arready}, 32'h0);
        ce <= 1'b1;
        // A write with the low byte lane off leaves the register alone.
        wstrb <= 4'h0;
        axi_wr(MASK_OFS, 32'h3, RESP_OKAY);
        wstrb <= 4'hf;
        axi_rd(MASK_OFS, 32'h0, RESP_OKAY);
        axi_rd(4'h1, 32'h0, RESP_SLVERR);
        axi_wr(4'h1, 32'h7, RESP_SLVERR);
        axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
        axi_wr(MASK_OFS, 32'h1, RESP_OKAY);
        tx_one(8'ha5, 1'b1);
        tx_one(8'h3c, 1'b0);
        axi_wr(MASK_OFS, 32'h2, RESP_OKAY);
        rx_one({1'b0, 8'h5a}, 1'b1);
        axi_rd(STAT_OFS, 32'h0, RESP_OKAY);
        axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
        rx_one({1'b0, 8'h5a}, 1'b0);
        axi_rd(DATA_OFS, 32'h5a, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h2, RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        rx_one({1'b1, 8'h77}, 1'b1);
        axi_rd(DATA_OFS, 32'h5a, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h2, RESP_OKAY);
        axi_wr(STAT_OFS, 32'h2, RESP_OKAY);
        axi_wr(CTRL_OFS, 32'h3, RESP_OKAY);
        // A short glitch would otherwise read as an all-ones address frame.
        node_u.glitch();
        repeat (BIT * 12) @(posedge clk);
        axi_rd(STAT_OFS, 32'h0, RESP_OKAY);
        rx_one({1'b0, 8'h66}, 1'b1);
        axi_rd(STAT_OFS, 32'h0, RESP_OKAY);
        rx_one({1'b1, 8'h42}, 1'b1);
        axi_rd(DATA_OFS, 32'h42, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h6, RESP_OKAY);
        test_done();
    end
endmodule
`default_nettype wire
